// [core/bws_map.svh]
`ifndef BWS_MAP_SVH
`define BWS_MAP_SVH

// word offset inside an eight-word group, word inside a 128-word line
`define BWS_GROUP_BITS 3
`define BWS_LINE_BITS 7
`define BWS_GROUP_LAST 3'h7
`define BWS_LINE_LAST 7'h7F

// initial wait states = wait code + base; code 0000 puts data on the 2nd edge
`define BWS_WS_BASE 5'h02

// from this many wait states up a first-group stall equals the start offset
`define BWS_FULL_STALL_WS 5'h09

// wait-state counts that add line-end stalls, and how many
`define BWS_LINE_EXTRA1_WS 5'h0A
`define BWS_LINE_EXTRA2_WS 5'h0B
`define BWS_LINE_EXTRA1 4'h1
`define BWS_LINE_EXTRA2 4'h2

// after reset the device reads asynchronously
`define BWS_SYNC_EN_RST 1'h0
`define BWS_WAIT_CODE_RST 4'h0

`endif

// [core/bws_pkg.sv]
package bws_pkg;

   typedef logic [3:0] bws_wait_code_t;

   typedef enum {
      BWS_IDLE,
      BWS_INIT,
      BWS_STREAM,
      BWS_STALL
   } bws_state_t;

endpackage

// [core/bws_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser; meta_q feeds q only
module bws_sync
   #(parameter int W = 1)
   (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
   );

   logic [W-1:0] meta_q;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

`default_nettype wire

// [core/bws_burst_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bws_map.svh"

// Contract
// R01 - low three address bits pick start offset
// R02 - wait code sets first data edge
// R03 - line crossing adds wait-dependent latency
// R04 - four waits: offsets six, seven stall
// R05 - three waits: only offset seven stalls once
// R06 - eleven waits: offset stalls plus two
// R07 - ten waits: offset stalls plus one
// R08 - nine waits: offset stalls, no extra
// R09 - eight waits: offset minus one stalls
// R10 - seven waits: offset minus two stalls
// R11 - six waits: offset minus three stalls
// R12 - five waits: offsets five-seven stall 1-3
// R13 - four waits crossing: six one, seven two
// R14 - three waits crossing: offset seven once
// R15 - eleven waits later crossing: two extra
// R16 - ten waits later crossing: one extra
// R17 - nine waits later crossing: no extra
// R18 - eight waits later: group stall only
// R19 - seven waits later: group stall only
// R20 - first and later crossings reported apart
// R21 - stall: ready low, word held
// R22 - host keeps clocking, enable low through stalls
module bws_burst_seq
   #(parameter int ADDR_W = 24)
   (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cfg_sync_en,
   input wire bws_pkg::bws_wait_code_t cfg_wait_code,
   output var logic cross_first_pulse,
   output var logic cross_later_pulse,
   input wire logic burst_clk,
   input wire logic ce_n,
   input wire logic address_valid_strobe_n,
   input wire logic [ADDR_W-1:0] link_addr,
   output var logic link_rdy,
   output var logic [ADDR_W-1:0] link_word
   );
   import bws_pkg::*;

   // system side: configuration held in flops before it crosses
   logic cfg_en_q;
   bws_wait_code_t cfg_code_q;
   logic [1:0] evt_s;
   logic [1:0] evt_p_q;
   logic first_pulse_q;
   logic later_pulse_q;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cfg_en_q <= `BWS_SYNC_EN_RST;
         cfg_code_q <= `BWS_WAIT_CODE_RST;
         evt_p_q <= 2'h0;
         first_pulse_q <= 1'h0;
         later_pulse_q <= 1'h0;
      end
      else
      begin
         cfg_en_q <= cfg_sync_en;
         cfg_code_q <= cfg_wait_code;
         evt_p_q <= evt_s;
         first_pulse_q <= evt_s[1] ^ evt_p_q[1];
         later_pulse_q <= evt_s[0] ^ evt_p_q[0];
      end
   end

   assign cross_first_pulse = first_pulse_q;
   assign cross_later_pulse = later_pulse_q;

   // link side: reset and configuration brought onto the burst clock
   logic link_rst_n;
   logic [4:0] cfg_s;
   logic cfg_en_s;
   bws_wait_code_t cfg_code_s;

   bws_sync #(.W(1)) u_rst_sync
   (
      .clk(burst_clk),
      .rst_n(1'h1),
      .d(rst_n),
      .q(link_rst_n)
   );

   bws_sync #(.W(5)) u_cfg_sync
   (
      .clk(burst_clk),
      .rst_n(link_rst_n),
      .d({cfg_en_q, cfg_code_q}),
      .q(cfg_s)
   );

   assign cfg_en_s = cfg_s[4];
   assign cfg_code_s = cfg_s[3:0];

   bws_state_t state_q;
   bws_state_t state_d;
   logic rdy_q;
   logic rdy_d;
   logic [ADDR_W-1:0] word_q;
   logic [ADDR_W-1:0] word_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [2:0] off0_q;
   logic [2:0] off0_d;
   logic first_q;
   logic first_d;
   logic first_tgl_q;
   logic first_tgl_d;
   logic later_tgl_q;
   logic later_tgl_d;

   // decode of the latency rows
   logic [4:0] ws_w;
   logic [4:0] base_w;
   logic [3:0] grp_stall_w;
   logic [3:0] line_extra_w;
   logic at_group_end_w;
   logic at_line_end_w;
   logic [3:0] gap_w;
   logic latch_w;
   logic [ADDR_W-1:0] word_next_w;

   assign ws_w = {1'h0, cfg_code_s} + `BWS_WS_BASE; // [R02]
   assign base_w = (ws_w >= `BWS_FULL_STALL_WS) ? 5'h00 : `BWS_FULL_STALL_WS - ws_w;
   // first-group stall = start offset less the slack of the row [R04] [R05] [R09] [R10] [R11] [R12]
   assign grp_stall_w = ({2'h0, off0_q} > base_w) ? 4'({2'h0, off0_q} - base_w) : 4'h0; // [R01]
   // extra line-end cycles [R03] [R06] [R07] [R08] [R15] [R16] [R17]
   assign line_extra_w = (ws_w >= `BWS_LINE_EXTRA2_WS) ? `BWS_LINE_EXTRA2 :
                         (ws_w == `BWS_LINE_EXTRA1_WS) ? `BWS_LINE_EXTRA1 : 4'h0;
   assign at_group_end_w = word_q[`BWS_GROUP_BITS-1:0] == `BWS_GROUP_LAST;
   assign at_line_end_w = word_q[`BWS_LINE_BITS-1:0] == `BWS_LINE_LAST;
   // a first-read crossing sums both; a later one only sees the line part [R13] [R14] [R18] [R19]
   assign gap_w = ((at_group_end_w && first_q) ? grp_stall_w : 4'h0) + (at_line_end_w ? line_extra_w : 4'h0);
   assign latch_w = !ce_n && !address_valid_strobe_n && cfg_en_s;
   assign word_next_w = word_q + ADDR_W'(1);

   always_comb
   begin
      state_d = state_q;
      rdy_d = rdy_q;
      word_d = word_q;
      cnt_d = cnt_q;
      off0_d = off0_q;
      first_d = first_q;
      first_tgl_d = first_tgl_q;
      later_tgl_d = later_tgl_q;
      if (ce_n)
      begin
         // enable high ends the burst; stalls rely on the host holding it low [R22]
         state_d = BWS_IDLE;
         rdy_d = 1'h0;
      end
      else if (latch_w)
      begin
         state_d = BWS_INIT;
         rdy_d = 1'h0;
         word_d = link_addr;
         off0_d = link_addr[`BWS_GROUP_BITS-1:0]; // [R01]
         first_d = 1'h1;
         cnt_d = ws_w - 5'h01; // [R02]
      end
      else
      begin
         case (state_q)
            BWS_IDLE:
            begin
               rdy_d = 1'h0;
            end
            BWS_INIT:
            begin
               if (cnt_q == 5'h01)
               begin
                  state_d = BWS_STREAM;
                  rdy_d = 1'h1; // [R02]
               end
               else
               begin
                  cnt_d = cnt_q - 5'h01;
               end
            end
            BWS_STREAM:
            begin
               if (at_group_end_w)
               begin
                  first_d = 1'h0;
               end
               if (at_line_end_w)
               begin
                  // first-read and later crossings reported on separate toggles [R20]
                  first_tgl_d = first_tgl_q ^ first_q;
                  later_tgl_d = later_tgl_q ^ !first_q;
               end
               if (gap_w != 4'h0)
               begin
                  // hold the word and drop ready while stalling [R21]
                  state_d = BWS_STALL;
                  rdy_d = 1'h0;
                  cnt_d = {1'h0, gap_w};
               end
               else
               begin
                  word_d = word_next_w;
               end
            end
            BWS_STALL:
            begin
               if (cnt_q == 5'h01)
               begin
                  state_d = BWS_STREAM;
                  rdy_d = 1'h1;
                  word_d = word_next_w; // [R21]
               end
               else
               begin
                  cnt_d = cnt_q - 5'h01;
               end
            end
            default:
            begin
               state_d = BWS_IDLE;
               rdy_d = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge burst_clk)
   begin
      if (!link_rst_n)
      begin
         state_q <= BWS_IDLE;
         rdy_q <= 1'h0;
         word_q <= '0;
         cnt_q <= 5'h00;
         off0_q <= 3'h0;
         first_q <= 1'h0;
      end
      else
      begin
         state_q <= state_d;
         rdy_q <= rdy_d;
         word_q <= word_d;
         cnt_q <= cnt_d;
         off0_q <= off0_d;
         first_q <= first_d;
      end
   end

   // toggles and their system-side copies clear together, so reset fakes no event edge
   always_ff @(posedge burst_clk)
   begin
      if (!link_rst_n)
      begin
         first_tgl_q <= 1'h0;
         later_tgl_q <= 1'h0;
      end
      else
      begin
         first_tgl_q <= first_tgl_d;
         later_tgl_q <= later_tgl_d;
      end
   end

   bws_sync #(.W(2)) u_evt_sync
   (
      .clk(sys_clk),
      .rst_n(rst_n),
      .d({first_tgl_q, later_tgl_q}),
      .q(evt_s)
   );

   assign link_rdy = rdy_q;
   assign link_word = word_q;

   // checking helpers: edges since latch, length of the current stall
   logic [4:0] lat_q;
   logic [3:0] gap_q;
   logic xfirst_q;

   always_ff @(posedge burst_clk)
   begin
      if (!link_rst_n)
      begin
         lat_q <= 5'h00;
         gap_q <= 4'h0;
         xfirst_q <= 1'h0;
      end
      else
      begin
         lat_q <= latch_w ? 5'h01 : ((lat_q == 5'h1F) ? lat_q : lat_q + 5'h01);
         gap_q <= (state_q == BWS_STALL) ? gap_q + 4'h1 : 4'h0;
         // remembers whether the last line end was met in the first group
         xfirst_q <= (state_q == BWS_STREAM && at_line_end_w) ? first_q : xfirst_q;
      end
   end

   logic stall_exit_w;
   logic group_exit_w;
   logic line_exit_w;

   assign stall_exit_w = state_q == BWS_STREAM && rdy_q && gap_q != 4'h0;
   assign group_exit_w = stall_exit_w && word_q[`BWS_GROUP_BITS-1:0] == 3'h0
                         && word_q[`BWS_LINE_BITS-1:0] != 7'h00;
   assign line_exit_w = stall_exit_w && word_q[`BWS_LINE_BITS-1:0] == 7'h00;

   sequence s_stall2;
      !rdy_q ##1 !rdy_q ##1 rdy_q;
   endsequence

   sequence s_stall1;
      !rdy_q ##1 rdy_q;
   endsequence

   logic step_w;
   assign step_w = state_q == BWS_STREAM && !ce_n && !latch_w;

   a_first_latency: assert property ( // [R02]
      @(posedge burst_clk) disable iff (!link_rst_n)
      ($past(state_q) == BWS_INIT && state_q == BWS_STREAM) |-> (lat_q == ws_w))
      else $error("first word not on the programmed edge");

   a_start_offset: assert property ( // [R01]
      @(posedge burst_clk) disable iff (!link_rst_n)
      latch_w |=> (off0_q == $past(link_addr[2:0]) && word_q == $past(link_addr)))
      else $error("start offset not taken from low address bits");

   a_stall_not_ready: assert property ( // [R21]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (state_q == BWS_STALL) |-> (!rdy_q && $stable(word_q)))
      else $error("ready or word moved during a stall");

   a_stream_advance: assert property ( // [R21]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && gap_w == 4'h0) |=> (rdy_q && word_q == $past(word_q) + ADDR_W'(1)))
      else $error("word did not advance on a ready cycle");

   a_ws4_off7: assert property ( // [R04]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && ws_w == 5'h04 && off0_q == 3'h7 && first_q && at_group_end_w && !at_line_end_w) |=> s_stall2)
      else $error("four wait states, offset seven: not two stalls");

   a_ws3_off7: assert property ( // [R05] [R14]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && ws_w == 5'h03 && off0_q == 3'h7 && first_q && at_group_end_w) |=> s_stall1)
      else $error("three wait states, offset seven: not one stall");

   a_low_no_stall: assert property ( // [R04] [R05] [R12]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && ws_w <= 5'h05 && off0_q <= 3'h4 && at_group_end_w && !at_line_end_w) |=> rdy_q)
      else $error("unexpected stall at low offset");

   a_ws11_line: assert property ( // [R15]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && ws_w == 5'h0B && !first_q && at_line_end_w) |=> s_stall2 ##0 word_q[6:0] == 7'h00)
      else $error("eleven wait states: line end not two stalls");

   a_ws10_line: assert property ( // [R16]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && ws_w == 5'h0A && !first_q && at_line_end_w) |=> s_stall1 ##0 word_q[6:0] == 7'h00)
      else $error("ten wait states: line end not one stall");

   a_no_line_extra: assert property ( // [R17] [R18] [R19]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && ws_w <= 5'h09 && !first_q && at_line_end_w) |=> (rdy_q && word_q[6:0] == 7'h00))
      else $error("line end stalled below ten wait states");

   a_first_cross_gap: assert property ( // [R06] [R07] [R08] [R03]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (line_exit_w && ws_w >= 5'h09 && ws_w <= 5'h0B && xfirst_q)
      |-> (gap_q == {1'h0, off0_q} + 4'(ws_w - 5'h09)))
      else $error("first-read crossing gap wrong");

   a_gap_ws8: assert property ( // [R09] [R18]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (group_exit_w && ws_w == 5'h08) |-> (gap_q == {1'h0, off0_q} - 4'h1))
      else $error("eight wait states: group stall not offset minus one");

   a_gap_ws7: assert property ( // [R10] [R19]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (group_exit_w && ws_w == 5'h07) |-> (gap_q == {1'h0, off0_q} - 4'h2))
      else $error("seven wait states: group stall not offset minus two");

   a_gap_ws6: assert property ( // [R11]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (group_exit_w && ws_w == 5'h06) |-> (gap_q == {1'h0, off0_q} - 4'h3))
      else $error("six wait states: group stall not offset minus three");

   a_gap_ws5: assert property ( // [R12]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (group_exit_w && ws_w == 5'h05) |-> (gap_q == {1'h0, off0_q} - 4'h4))
      else $error("five wait states: group stall not offset minus four");

   a_cross_report: assert property ( // [R20]
      @(posedge burst_clk) disable iff (!link_rst_n)
      (step_w && at_line_end_w) |=> ($changed(first_tgl_q) == $past(first_q)
                                     && $changed(later_tgl_q) == !$past(first_q)))
      else $error("crossing reported on the wrong toggle");

endmodule

`default_nettype wire

// [tb/bws_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// host side of the burst link: makes the burst clock, latches a start address and logs the first 32 ready beats
module bws_host_model
   (
   output var logic burst_clk,
   output var logic ce_n,
   output var logic address_valid_strobe_n,
   output var logic [23:0] link_addr,
   input wire logic link_rdy,
   input wire logic [23:0] link_word
   );
   logic [23:0] got_word [0:31];
   int got_edge [0:31];
   int got_n = 0;
   int edge_n = 0;
   int held_bad = 0;

   // runs free so the link side sees its reset edges
   initial
   begin
      burst_clk = 1'h0;
      #7;
      forever #32 burst_clk = ~burst_clk;
   end

   initial
   begin
      ce_n = 1'h1;
      address_valid_strobe_n = 1'h1;
      link_addr = 24'h5A5A5A;
   end

   task automatic burst(input logic [23:0] a, input int beats);
      @(negedge burst_clk);
      ce_n = 1'h0;
      address_valid_strobe_n = 1'h0;
      link_addr = a;
      @(negedge burst_clk);
      address_valid_strobe_n = 1'h1;
      // released address lines carry garbage
      link_addr = ~a;
      while (got_n < beats && edge_n < 60)
         @(negedge burst_clk);
      ce_n = 1'h1;
   endtask

   always @(posedge burst_clk)
   begin
      if (!ce_n && !address_valid_strobe_n)
      begin
         edge_n <= 0;
         got_n <= 0;
         held_bad <= 0;
      end
      else
      begin
         edge_n <= edge_n + 1;
         if (!ce_n && link_rdy === 1'h1 && got_n < 32)
         begin
            // data taken only on ready edges
            got_word[got_n] <= link_word;
            got_edge[got_n] <= edge_n + 1;
            got_n <= got_n + 1;
         end
         else if (!ce_n && got_n > 0 && link_word !== got_word[got_n-1])
            held_bad <= held_bad + 1;
      end
   end
endmodule

`default_nettype wire

// [tb/burst_read_wait_state_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module burst_read_wait_state_sequencer_bench;
   import bws_pkg::*;
   logic sys_clk, rst_n, cfg_sync_en, first_p, later_p, burst_clk, ce_n, strobe_n, link_rdy;
   bws_wait_code_t cfg_wait_code;
   logic [23:0] link_addr, link_word;
   int errors, checked, n_first, n_later, cycles;

   bws_burst_seq #(.ADDR_W(24)) dut
      (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cfg_sync_en(cfg_sync_en),
      .cfg_wait_code(cfg_wait_code),
      .cross_first_pulse(first_p),
      .cross_later_pulse(later_p),
      .burst_clk(burst_clk),
      .ce_n(ce_n),
      .address_valid_strobe_n(strobe_n),
      .link_addr(link_addr),
      .link_rdy(link_rdy),
      .link_word(link_word)
      );

   bws_host_model host
      (
      .burst_clk(burst_clk),
      .ce_n(ce_n),
      .address_valid_strobe_n(strobe_n),
      .link_addr(link_addr),
      .link_rdy(link_rdy),
      .link_word(link_word)
      );

   initial
   begin
      sys_clk = 1'h0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (first_p === 1'h1)
         n_first++;
      if (later_p === 1'h1)
         n_later++;
      if (cycles == 90000)
      begin
         errors++;
         summarize();
      end
   end

   // strobes are ignored while burst reads are off
   task automatic t_refused();
      host.burst(24'h000010, 1);
      check("async beats", host.got_n, 0);
   endtask

   // one burst; expected beat edges built from the latency tables
   task automatic run(input logic [3:0] code, input logic [23:0] a, input int beats);
      int ws, off, e, lim;
      logic [23:0] w;
      @(negedge sys_clk);
      cfg_wait_code = code;
      repeat (4) @(posedge burst_clk);
      n_first = 0;
      n_later = 0;
      host.burst(a, beats);
      repeat (3) @(posedge burst_clk);
      ws = code + 2;
      off = a[2:0];
      lim = (ws < 9) ? 9 - ws : 0;
      e = ws;
      for (int k = 0; k < beats; k++)
      begin
         w = a + k;
         if (k > 0 && w[6:0] == 7'h00)
            e += (ws >= 11) ? 2 : ((ws == 10) ? 1 : 0);
         if (k == 8 - off && off > lim)
            e += off - lim;
         check("word", host.got_word[k], w);
         check("beat edge", host.got_edge[k], e);
         e++;
      end
      check("held word", host.held_bad, 0);
      check("first report", n_first, a[6:3] == 4'hF);
      check("later report", n_later, a[6:3] == 4'hE);
   endtask

   initial
   begin
      rst_n = 1'h0;
      cfg_sync_en = 1'h0;
      cfg_wait_code = 4'h0;
      errors = 0;
      checked = 0;
      cycles = 0;
      n_first = 0;
      n_later = 0;
      repeat (8) @(posedge sys_clk);
      // link side needs burst clock edges inside reset too
      repeat (3) @(posedge burst_clk);
      @(negedge sys_clk);
      rst_n = 1'h1;
      repeat (4) @(posedge burst_clk);
      t_refused();
      @(negedge sys_clk);
      cfg_sync_en = 1'h1;
      for (int c = 0; c < 10; c++)
         for (int o = 0; o < 8; o++)
         begin
            run(4'(c), 24'h0A0078 + 24'(o), 10);
            run(4'(c), 24'h0A0070 + 24'(o), 17);
         end
      // codes above eleven wait states take the eleven-state line penalty
      run(4'hF, 24'h0A007F, 10);
      run(4'hF, 24'h0A0075, 17);
      summarize();
   end
endmodule

`default_nettype wire
